//--- hw/ssp_phase_ctrl.sv
// Soft-start phase-angle controller for a mixed diode/thyristor bridge.
// Assumes a clean comparator level on ZERO_CROSS_SENSE (high = positive line),
// a level start request, and a simple strobe register port on the same clock.
`timescale 1ns/1ps

module ssp_phase_ctrl #(
   parameter int LEAD_CYC     = ssp_pkg::FIRST_FIRE_LEAD_CYC,
   parameter int PULSE_CYC    = ssp_pkg::GATE_PULSE_CYC,
   parameter int OFFSET_CYC   = ssp_pkg::TURN_ON_OFFSET_CYC,
   parameter int STEP_MIN_CYC = ssp_pkg::STEP_MIN_CYC,
   parameter int STEP_MAX_CYC = ssp_pkg::STEP_MAX_CYC,
   parameter int CONT_CYC     = ssp_pkg::CONT_DELAY_CYC,
   parameter int MAX_ON_CYC   = ssp_pkg::MAX_ON_CYC
) (
   input  wire logic                       CLK,
   input  wire logic                       RESET,
   input  wire logic                       ZERO_CROSS_SENSE,
   input  wire logic                       EXTERNAL_SOFT_START_REQUEST,
   input  wire logic [ssp_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [ssp_pkg::DATA_W-1:0] WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic      [ssp_pkg::DATA_W-1:0] RDATA,
   output logic                            POSITIVE_THYRISTOR_GATE,
   output logic                            NEGATIVE_THYRISTOR_GATE
);

   // ****************************************************************
   // Constants at counter width
   // ****************************************************************
   localparam int CW = ssp_pkg::CNT_W;
   localparam logic [CW-1:0] lead_c   = CW'(LEAD_CYC);
   localparam logic [CW-1:0] pulse_c  = CW'(PULSE_CYC);
   localparam logic [CW-1:0] offset_c = CW'(OFFSET_CYC);
   localparam logic [CW-1:0] cont_c   = CW'(CONT_CYC);
   localparam logic [CW-1:0] max_on_c = CW'(MAX_ON_CYC);
   localparam logic [CW-1:0] cnt_top  = {CW{1'b1}};
   localparam int STEP_INC = (STEP_MAX_CYC - STEP_MIN_CYC) / (ssp_pkg::STEP_POS_MAX - ssp_pkg::STEP_POS_MIN);

   // Step size from selector position; out-of-range codes clamp to the ends
   function automatic logic [CW-1:0] step_of(input logic [2:0] pos);
      int p;
      p = int'(pos);
      if (p < ssp_pkg::STEP_POS_MIN) p = ssp_pkg::STEP_POS_MIN;
      if (p > ssp_pkg::STEP_POS_MAX) p = ssp_pkg::STEP_POS_MAX;
      return CW'(STEP_MIN_CYC + (p - ssp_pkg::STEP_POS_MIN) * STEP_INC);
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   ssp_pkg::ssp_bus_s   bus;            // Register request bundle
   ssp_pkg::ssp_state_e state_q;        // Sequencer state
   ssp_pkg::ssp_state_e state_d;
   ssp_pkg::ssp_gates_s gates_q;        // Registered gate drive
   ssp_pkg::ssp_gates_s gates_d;
   logic [1:0]          sync_out;       // Synchronised sense and start
   logic                sense_s;        // Line polarity, high = positive
   logic                start_s;        // Start request
   logic                sense_q;        // Previous polarity for edge detect
   logic                zc;             // Zero crossing this cycle
   logic [CW-1:0]       cnt_q;          // Cycles since last crossing
   logic [CW-1:0]       half_q;         // Last measured half-cycle
   logic [CW-1:0]       delay_q;        // Present firing delay
   logic [CW-1:0]       delay_d;
   logic [CW-1:0]       dec_delay;      // Delay after one step
   logic [CW-1:0]       step_q;         // Step in cycles
   logic [2:0]          step_pos_q;     // Software step position
   logic                en_q;           // Software enable
   logic                seen_q;         // One crossing seen in MEAS
   logic                run;            // Start and enable both present
   logic                fire_win;       // Pulsed firing window
   logic                cont_win;       // Continuous drive window
   logic                drive;          // Gate wanted this cycle
   logic [CW-1:0]       on_cnt_q;       // Consecutive gate-on cycles
   logic [ssp_pkg::DATA_W-1:0] rd_mux;  // Read data before register

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   ssp_sync #(.W(2)) u_sync (
      .CLK   (CLK),
      .RESET (RESET),
      .D     ({ZERO_CROSS_SENSE, EXTERNAL_SOFT_START_REQUEST}),
      .Q     (sync_out)
   );

   assign sense_s = sync_out[1];
   assign start_s = sync_out[0];
   // A line high at reset shows one false crossing, seen only while idle
   // Each comparator edge marks a zero crossing and new polarity
   assign zc      = sense_s ^ sense_q;
   assign run     = start_s & en_q;

   // ****************************************************************
   // Half-cycle timing
   // ****************************************************************
   // Counter restarts at each crossing and saturates if the line stops
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sense_q <= 1'b0;
         cnt_q   <= '0;
         half_q  <= '0;
      end else begin
         sense_q <= sense_s;
         if (zc) begin
            cnt_q  <= '0;
            half_q <= (cnt_q == cnt_top) ? cnt_top : cnt_q + 1'b1;
         end else if (cnt_q != cnt_top) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // Constant step every half-cycle, floored at zero
   assign dec_delay = (delay_q > step_q) ? delay_q - step_q : '0;

   always_comb begin
      state_d = state_q;
      delay_d = delay_q;
      unique case (state_q)
         ssp_pkg::ST_IDLE: begin
            // Nothing fires until a start request is seen
            if (run) state_d = ssp_pkg::ST_MEAS;
         end
         ssp_pkg::ST_MEAS: begin
            // Second crossing gives a full half; aim just before the next
            if (zc && seen_q) begin
               state_d = ssp_pkg::ST_PULSE;
               delay_d = (cnt_q + 1'b1 > lead_c) ? cnt_q + 1'b1 - lead_c : '0;
            end
         end
         ssp_pkg::ST_PULSE: begin
            // Once the delay drops under the threshold drive continuously
            if (zc) begin
               delay_d = dec_delay;
               if (dec_delay < cont_c) state_d = ssp_pkg::ST_CONT;
            end
         end
         ssp_pkg::ST_CONT: begin
            state_d = ssp_pkg::ST_CONT;
         end
         default: begin
            state_d = ssp_pkg::ST_IDLE;
         end
      endcase
      // Dropped start or a lost line abort everything
      if (!run || (state_q != ssp_pkg::ST_IDLE && cnt_q == cnt_top)) begin
         state_d = ssp_pkg::ST_IDLE;
      end
   end

   // State, delay and the MEAS crossing flag
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_q <= ssp_pkg::ST_IDLE;
         delay_q <= '0;
         seen_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         delay_q <= delay_d;
         seen_q  <= (state_q == ssp_pkg::ST_MEAS) && (seen_q || zc);
      end
   end

   // ****************************************************************
   // Gate drive
   // ****************************************************************
   // Pulse window ends 50 us after firing, well ahead of the crossing
   assign fire_win = (state_q == ssp_pkg::ST_PULSE) && !zc &&
                     (cnt_q >= delay_q) && (cnt_q < delay_q + pulse_c);
   // Continuous drive starts the offset after the crossing and is capped
   assign cont_win = (state_q == ssp_pkg::ST_CONT) && !zc &&
                     (cnt_q >= offset_c) && (on_cnt_q < max_on_c);
   assign drive    = fire_win | cont_win;
   // Polarity picks the one thyristor that may conduct
   assign gates_d  = '{pos: drive & sense_s, neg: drive & ~sense_s};

   // Gate outputs and on-time counter; the counter is the 7 ms guard
   always_ff @(posedge CLK) begin
      if (RESET) begin
         gates_q  <= '0;
         on_cnt_q <= '0;
      end else begin
         gates_q  <= gates_d;
         // Cleared at each crossing, so the cap holds per half-cycle and
         // a capped gate cannot come back before the next crossing
         if (zc || state_q == ssp_pkg::ST_IDLE) begin
            on_cnt_q <= '0;
         end else if (gates_d.pos | gates_d.neg) begin
            on_cnt_q <= on_cnt_q + 1'b1;
         end
      end
   end

   assign POSITIVE_THYRISTOR_GATE = gates_q.pos;
   assign NEGATIVE_THYRISTOR_GATE = gates_q.neg;

   // ****************************************************************
   // Register port
   // ****************************************************************
   // Writes: enable and step position; step cycles kept registered
   // A step write during a sequence waits for the next idle spell
   always_ff @(posedge CLK) begin
      if (RESET) begin
         en_q       <= ssp_pkg::CTRL_EN_RST;
         step_pos_q <= ssp_pkg::STEP_RST;
         step_q     <= step_of(ssp_pkg::STEP_RST);
      end else begin
         if (bus.wr && bus.addr == ssp_pkg::REG_CTRL) en_q <= bus.wdata[ssp_pkg::CTRL_EN_BIT];
         if (bus.wr && bus.addr == ssp_pkg::REG_STEP) begin
            step_pos_q <= bus.wdata[2:0];
         end
         // Step held constant during a sequence so every half uses it
         if (state_q == ssp_pkg::ST_IDLE) step_q <= step_of(step_pos_q);
      end
   end

   // Unmapped addresses read as zero
   // Status packs pos gate, neg gate, synced polarity and one-hot state
   assign rd_mux = (bus.addr == ssp_pkg::REG_CTRL)   ? {31'h0, en_q} :
                   (bus.addr == ssp_pkg::REG_STEP)   ? {29'h0, step_pos_q} :
                   (bus.addr == ssp_pkg::REG_STATUS) ? {24'h0, gates_q, sense_s, state_q} :
                   (bus.addr == ssp_pkg::REG_DELAY)  ? {11'h0, delay_q} :
                   (bus.addr == ssp_pkg::REG_HALF)   ? {11'h0, half_q} : 32'h0;

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge CLK) begin
      if (RESET) RDATA <= '0;
      else       RDATA <= bus.rd ? rd_mux : '0;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // Crossing-relative checks rely on cnt_q restarting the cycle after zc

   chk_gates_exclusive: assert property (!(gates_q.pos && gates_q.neg))
      else $error("both gates driven");
   chk_gate_polarity: assert property (
      (gates_q.pos |-> $past(sense_s)) and (gates_q.neg |-> !$past(sense_s)))
      else $error("gate driven against line polarity");
   chk_first_fire: assert property (
      $rose(state_q == ssp_pkg::ST_PULSE) && half_q > lead_c |-> delay_q == half_q - lead_c)
      else $error("first firing not placed ahead of crossing");
   chk_pulse_width: assert property (
      state_q == ssp_pkg::ST_PULSE |-> on_cnt_q <= pulse_c)
      else $error("pulsed firing too long");
   chk_step_const: assert property (
      state_q == ssp_pkg::ST_PULSE && zc && delay_q > step_q |=> delay_q == $past(delay_q) - $past(step_q))
      else $error("delay step not applied");
   chk_step_range: assert property (
      step_q >= CW'(STEP_MIN_CYC) && step_q <= CW'(STEP_MAX_CYC))
      else $error("step outside selector range");
   chk_cont_offset: assert property (
      state_q == ssp_pkg::ST_CONT && $rose(gates_q.pos | gates_q.neg) |-> $past(cnt_q) == offset_c)
      else $error("continuous drive not at turn-on offset");
   chk_cont_entry: assert property (
      state_q == ssp_pkg::ST_PULSE && zc && run && dec_delay < cont_c && cnt_q != cnt_top
      |=> state_q == ssp_pkg::ST_CONT)
      else $error("continuous drive not entered");
   chk_max_on: assert property (on_cnt_q <= max_on_c)
      else $error("gate on time above limit");
   chk_idle_quiet: assert property (
      $past(state_q) == ssp_pkg::ST_IDLE |-> !(gates_q.pos || gates_q.neg))
      else $error("gate driven while idle");
   chk_abort_off: assert property (!run |=> !(gates_q.pos || gates_q.neg))
      else $error("gate driven after request dropped");
   chk_pulse_start: assert property (
      $rose(gates_q.pos | gates_q.neg) && state_q == ssp_pkg::ST_PULSE |-> $past(cnt_q) == delay_q)
      else $error("pulsed firing not at firing delay");
   chk_delay_hold: assert property (
      state_q == ssp_pkg::ST_PULSE && !zc |=> delay_q == $past(delay_q))
      else $error("firing delay moved inside a half-cycle");
   chk_rdata_idle: assert property (!$past(RD) |-> RDATA == '0)
      else $error("read data outside its cycle");

   cov_pulse_entry: cover property ($rose(state_q == ssp_pkg::ST_PULSE));
   cov_cont_entry:  cover property ($rose(state_q == ssp_pkg::ST_CONT));
   cov_neg_pulse:   cover property ($rose(gates_q.neg) && state_q == ssp_pkg::ST_PULSE);
   cov_step_write:  cover property (bus.wr && bus.addr == ssp_pkg::REG_STEP);
   cov_cap_hit:     cover property (state_q == ssp_pkg::ST_CONT && on_cnt_q == max_on_c);

endmodule

//--- pkg/ssp_pkg.sv
// Shared constants and types for the soft-start phase controller.
// Assumes a single 100 MHz clock; all times are turned into cycle counts here.
package ssp_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_MHZ                = 100;    // Cycles per microsecond
   localparam int FIRST_FIRE_LEAD_US     = 150;    // First firing ahead of zero crossing
   localparam int GATE_PULSE_US          = 50;     // Length of a pulsed firing
   localparam int GATE_RELEASE_MARGIN_US = 100;    // Gate off ahead of half-cycle end
   localparam int TURN_ON_OFFSET_US      = 100;    // Turn-on after zero crossing
   localparam int STEP_MIN_US            = 50;     // Smallest delay step
   localparam int STEP_MAX_US            = 600;    // Largest delay step
   localparam int CONT_DELAY_US          = 3000;   // Below this, continuous drive
   localparam int MAX_ON_US              = 7000;   // Longest gate on time per half-cycle

   // Cycle counts (whole microseconds, so no rounding is involved)
   localparam int FIRST_FIRE_LEAD_CYC     = FIRST_FIRE_LEAD_US * CLK_MHZ;
   localparam int GATE_PULSE_CYC          = GATE_PULSE_US * CLK_MHZ;
   localparam int GATE_RELEASE_MARGIN_CYC = GATE_RELEASE_MARGIN_US * CLK_MHZ;
   localparam int TURN_ON_OFFSET_CYC      = TURN_ON_OFFSET_US * CLK_MHZ;
   localparam int STEP_MIN_CYC            = STEP_MIN_US * CLK_MHZ;
   localparam int STEP_MAX_CYC            = STEP_MAX_US * CLK_MHZ;
   localparam int CONT_DELAY_CYC          = CONT_DELAY_US * CLK_MHZ;
   localparam int MAX_ON_CYC              = MAX_ON_US * CLK_MHZ;

   // Counter width: covers a half-cycle at the slowest line with margin
   localparam int CNT_W = 21;

   // ****************************************************************
   // Step selector positions
   // ****************************************************************
   localparam int STEP_POS_W   = 3;
   localparam int STEP_POS_MIN = 1;   // Default, slowest charge
   localparam int STEP_POS_MAX = 6;   // Fastest charge

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int              ADDR_W     = 8;
   localparam int              DATA_W     = 32;
   localparam logic [7:0]      REG_CTRL   = 8'h00;   // Bit 0: enable
   localparam logic [7:0]      REG_STEP   = 8'h04;   // Bits 2:0: step position
   localparam logic [7:0]      REG_STATUS = 8'h08;   // State, polarity, gates
   localparam logic [7:0]      REG_DELAY  = 8'h0c;   // Present firing delay
   localparam logic [7:0]      REG_HALF   = 8'h10;   // Measured half-cycle
   localparam int              CTRL_EN_BIT = 0;
   localparam logic            CTRL_EN_RST = 1'h1;
   localparam logic [2:0]      STEP_RST    = 3'h1;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,   // Gates off, waiting for start
      ST_MEAS  = 5'h02,   // Learning half-cycle length
      ST_PULSE = 5'h04,   // Pulsed firing, delay shrinking
      ST_CONT  = 5'h08,   // Continuous gate drive
      ST_SPARE = 5'h10    // Unused code, never entered
   } ssp_state_e;

   typedef struct packed {
      logic pos;   // Positive half-cycle thyristor
      logic neg;   // Negative half-cycle thyristor
   } ssp_gates_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ssp_bus_s;

endpackage

//--- hw/ssp_sync.sv
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps

module ssp_sync #(
   parameter int W = 1   // Number of bits
) (
   input  wire logic         CLK,
   input  wire logic         RESET,
   input  wire logic [W-1:0] D,
   output logic      [W-1:0] Q
);

   logic [W-1:0] meta_q;   // First stage, read only by the second

   // Both stages clear on reset so the block sees a quiet line
   always_ff @(posedge CLK) begin
      if (RESET) begin
         meta_q <= '0;
         Q      <= '0;
      end else begin
         meta_q <= D;
         Q      <= meta_q;
      end
   end

endmodule

//--- dv/ssp_line_model.sv
// Line-side partner: zero-crossing comparator plus a gate drive observer.
// Assumes HALF_CYC clocks per line half-cycle and active-high gate drives.
`timescale 1ns/1ps

module ssp_line_model #(
   parameter int HALF_CYC = 2000   // Clocks per line half-cycle
) (
   input  wire logic CLK,
   input  wire logic RESET,
   output logic      SENSE,
   input  wire logic POS_GATE,
   input  wire logic NEG_GATE,
   output int        BAD_POL
);
   int since_q;   // Clocks since the last crossing

   initial begin
      SENSE   = 1'b1;
      since_q = 0;
      BAD_POL = 0;
   end

   // ****************************************************************
   // Comparator
   // ****************************************************************
   // The mains runs free of our reset, so the comparator ignores it
   always @(posedge CLK) begin
      if (since_q == HALF_CYC - 1) begin
         since_q <= 0;
         SENSE   <= ~SENSE;
      end else begin
         since_q <= since_q + 1;
      end
   end

   // ****************************************************************
   // Gate drive observer
   // ****************************************************************
   // Allows 8 clocks after a crossing for the controller's input sync lag
   always @(posedge CLK) begin
      if (!RESET && ((POS_GATE && NEG_GATE) || (since_q > 8 && (SENSE ? NEG_GATE : POS_GATE)))) begin
         BAD_POL <= BAD_POL + 1;
      end
   end
endmodule

//--- dv/ssp_phase_ctrl_tb_top.sv
// Self-checking bench for the soft-start phase controller.
// Assumes shortened timing parameters: one clock per microsecond, with the continuous threshold and on-time cap cut further.
`timescale 1ns/1ps

module ssp_phase_ctrl_tb_top;
   localparam int HALF  = 2000;   // Line half-cycle in clocks
   localparam int LEAD  = 150;    // First firing lead
   localparam int PULSE = 50;     // Pulsed firing length
   localparam int SMIN  = 50;     // Smallest step
   localparam int SMAX  = 600;    // Largest step
   localparam int OFFS  = 100;    // Turn-on offset in continuous drive
   localparam int CONT  = 600;    // Continuous drive threshold
   localparam int MAXON = 700;    // Gate on-time cap per half

   logic        CLK   = 1'b0;   // System clock
   logic        RESET = 1'b1;   // Synchronous reset
   logic        start = 1'b0;   // Soft-start request
   logic [7:0]  addr  = 8'h00;  // Register address
   logic [31:0] wdata = 32'h0;  // Register write data
   logic        wr    = 1'b0;   // Write strobe
   logic        rd    = 1'b0;   // Read strobe
   wire  [31:0] rdata;          // Register read data
   wire         sense;          // Comparator level
   wire         pos_g;          // Positive thyristor gate
   wire         neg_g;          // Negative thyristor gate
   int          bad_pol;        // Polarity faults seen by the line model
   int          n_errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;        // Free-running clock count
   int          t_edge = 0;     // Clock count at the last crossing
   logic        sense_d = 1'b1; // Sense seen on the previous edge

   always #5 CLK = ~CLK;

   ssp_phase_ctrl #(.LEAD_CYC(LEAD), .PULSE_CYC(PULSE), .OFFSET_CYC(OFFS), .STEP_MIN_CYC(SMIN),
      .STEP_MAX_CYC(SMAX), .CONT_CYC(CONT), .MAX_ON_CYC(MAXON)) u_dut (
      .CLK(CLK), .RESET(RESET), .ZERO_CROSS_SENSE(sense), .EXTERNAL_SOFT_START_REQUEST(start),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .POSITIVE_THYRISTOR_GATE(pos_g), .NEGATIVE_THYRISTOR_GATE(neg_g));

   ssp_line_model #(.HALF_CYC(HALF)) u_line (
      .CLK(CLK), .RESET(RESET), .SENSE(sense), .POS_GATE(pos_g), .NEG_GATE(neg_g), .BAD_POL(bad_pol));

   // Crossing time stamp, so firing delays are measured from the line
   always @(posedge CLK) begin
      cyc = cyc + 1;
      if (sense !== sense_d) begin
         t_edge = cyc;
      end
      sense_d = sense;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge CLK);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      addr <= a;
      rd   <= 1'b1;
      @(posedge CLK);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Waits for the next firing; returns its delay from the crossing and width
   task automatic pulse(output int rel, output int wid);
      int n;
      n = 0;
      while ((pos_g | neg_g) !== 1'b1 && n < 3 * HALF) begin
         @(posedge CLK);
         #1;
         n++;
      end
      rel = cyc - t_edge;
      check({30'h0, pos_g, neg_g}, sense ? 32'h2 : 32'h1, "gate polarity");
      wid = 0;
      while ((pos_g | neg_g) === 1'b1 && wid < HALF) begin
         @(posedge CLK);
         #1;
         wid++;
      end
   endtask

   task automatic summarize;
      $display("Comparisons: %0d, mismatches: %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] d;
      int          r1, r2, w1, w2, t0, n, stp;
      repeat (16) @(posedge CLK);
      RESET <= 1'b0;
      #1;
      check({30'h0, pos_g, neg_g}, 32'h0, "gates after reset");
      reg_rd(ssp_pkg::REG_CTRL, d);
      check(d, 32'h1, "ctrl reset");
      reg_rd(ssp_pkg::REG_STEP, d);
      check(d, 32'h1, "step reset");
      reg_rd(ssp_pkg::REG_STATUS, d);
      check({27'h0, d[4:0]}, {27'h0, ssp_pkg::ST_IDLE}, "idle state");
      reg_rd(8'h14, d);
      check(d, 32'h0, "unmapped read");
      // Line runs for three halves with no request: nothing may fire
      n = 0;
      repeat (3 * HALF) begin
         @(posedge CLK);
         #1;
         n += int'(pos_g | neg_g);
      end
      check(32'(n), 32'h0, "idle gates");
      // Cleared enable: a request must leave the block idle
      reg_wr(ssp_pkg::REG_CTRL, 32'h0);
      reg_rd(ssp_pkg::REG_CTRL, d);
      check(d, 32'h0, "ctrl cleared");
      @(posedge CLK);
      start <= 1'b1;
      repeat (8) @(posedge CLK);
      #1;
      check({30'h0, pos_g, neg_g}, 32'h0, "disabled gates");
      reg_rd(ssp_pkg::REG_STATUS, d);
      check({27'h0, d[4:0]}, {27'h0, ssp_pkg::ST_IDLE}, "disabled idle");
      @(posedge CLK);
      start <= 1'b0;
      reg_wr(ssp_pkg::REG_CTRL, 32'h1);
      // Every selector position: two pulses, their delays from the crossing differ by the step
      for (int p = 1; p <= 6; p++) begin
         stp = SMIN + (p - 1) * (SMAX - SMIN) / 5;
         reg_wr(ssp_pkg::REG_STEP, 32'(p));
         reg_rd(ssp_pkg::REG_STEP, d);
         check(d, 32'(p), "step readback");
         @(posedge CLK);
         start <= 1'b1;
         pulse(r1, w1);
         check(32'(w1), 32'(PULSE), "pulse width");
         check({31'h0, r1 >= HALF - LEAD && r1 <= HALF - LEAD + 6}, 32'h1, "first fire");
         reg_rd(ssp_pkg::REG_DELAY, d);
         check(d, 32'(HALF - LEAD), "first delay");
         reg_rd(ssp_pkg::REG_HALF, d);
         check(d, 32'(HALF), "measured half");
         pulse(r2, w2);
         check(32'(w2), 32'(PULSE), "pulse width");
         check(32'(r1 - r2), 32'(stp), "delay step");
         if (p == 6) begin
            // 1250 drops to 650, then 50 is below the 600 threshold
            pulse(r1, w1);
            check(32'(r2 - r1), 32'(stp), "third step");
            t0 = t_edge;
            n  = 0;
            while (t_edge == t0 && n < 3 * HALF) begin
               @(posedge CLK);
               #1;
               n++;
            end
            repeat (400) @(posedge CLK);
            #1;
            check({30'h0, pos_g, neg_g}, sense ? 32'h2 : 32'h1, "continuous drive");
            reg_rd(ssp_pkg::REG_STATUS, d);
            check({27'h0, d[4:0]}, {27'h0, ssp_pkg::ST_CONT}, "cont state");
            repeat (500) @(posedge CLK);
            #1;
            check({30'h0, pos_g, neg_g}, 32'h0, "on-time cap");
            // Next half: drive starts at the offset and stops at the cap
            pulse(r1, w1);
            check({31'h0, r1 >= OFFS && r1 <= OFFS + 6}, 32'h1, "turn-on offset");
            check(32'(w1), 32'(MAXON), "capped on time");
         end
         // Dropping the request aborts: gates off, back to idle
         @(posedge CLK);
         start <= 1'b0;
         repeat (8) @(posedge CLK);
         #1;
         check({30'h0, pos_g, neg_g}, 32'h0, "abort gates");
         reg_rd(ssp_pkg::REG_STATUS, d);
         check({27'h0, d[4:0]}, {27'h0, ssp_pkg::ST_IDLE}, "abort idle");
      end
      check(32'(bad_pol), 32'h0, "polarity faults");
      summarize();
   end

   // Whole run is about 49k clocks; a hang is cut at 90k
   initial begin
      repeat (90000) @(posedge CLK);
      n_errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      summarize();
   end
endmodule
